// ===== hw/dflc_ds3_far_end_loop.v
// DS-3 far-end alarm and control loopback controller with APB registers.
`timescale 1ns/1ns
`default_nettype none
`include "dflc_consts.vh"
module dflc_ds3_far_end_loop #(
   parameter RX_ONLY   = 0,
   parameter NUM_DS1   = 28,
   parameter TX_REPEAT = `DFLC_TX_REPEAT,
   parameter RX_ACCEPT = `DFLC_RX_ACCEPT
) (
   input  wire                pclk,
   input  wire                presetn,
   input  wire [7:0]          paddr,
   input  wire                psel,
   input  wire                penable,
   input  wire                pwrite,
   input  wire [31:0]         pwdata,
   output reg  [31:0]         prdata,
   output wire                pready,
   output wire                pslverr,
   input  wire                feac_tx_slot,
   output reg                 feac_tx_bit,
   input  wire                feac_rx_slot,
   input  wire                feac_rx_bit,
   output wire                ds3_line_loop,
   output wire [NUM_DS1-1:0]  ds1_line_loop,
   output reg                 ds3_loop_cmd_sent_alarm,
   output reg  [NUM_DS1-1:0]  ds1_loop_cmd_sent_alarm,
   output reg                 ds3_remote_loop_alarm,
   output reg  [NUM_DS1-1:0]  ds1_remote_loop_alarm,
   output wire                irq
);

   localparam NENT = NUM_DS1 + 1;
   localparam ST_IDLE = 2'b01;
   localparam ST_SEND = 2'b10;

   // Software state.
   reg  [`DFLC_CTRL_W-1:0] ctrl_reg;
   reg  [NUM_DS1-1:0]      ds1_send_reg;
   reg  [`DFLC_INT_W-1:0]  int_stat_reg;
   reg  [`DFLC_INT_W-1:0]  int_mask_reg;
   // Transmit state.
   reg  [1:0]              tx_state_reg;
   reg  [NENT-1:0]         sent_reg;
   reg  [4:0]              tx_sel_reg;
   reg                     tx_val_reg;
   reg  [15:0]             tx_word_reg;
   reg  [3:0]              tx_bit_reg;
   reg  [7:0]              tx_rep_reg;
   // Receive state.
   reg  [15:0]             rx_sr_reg;
   reg  [4:0]              rx_gap_reg;
   reg  [5:0]              rx_code_reg;
   reg  [7:0]              rx_hits_reg;
   reg                     ds3_remote_reg;
   reg  [NUM_DS1-1:0]      ds1_remote_reg;

   wire        wr_en  = psel & penable & pwrite;
   wire        rd_set = psel & ~penable & ~pwrite;
   wire        qual;
   wire [NENT-1:0] req;
   wire [NENT-1:0] mism;
   reg  [4:0]  pick;
   reg         pick_ok;
   integer     i;

   // Zero wait states keep the bus simple; the block never needs to stall.
   assign pready = 1'b1;
   assign pslverr = psel & penable &
                    (paddr != `DFLC_OFF_CTRL) &
                    (paddr != `DFLC_OFF_DS1_SEND) &
                    (paddr != `DFLC_OFF_STATUS) &
                    (paddr != `DFLC_OFF_DS1_LOOP) &
                    (paddr != `DFLC_OFF_INT_STAT) &
                    (paddr != `DFLC_OFF_INT_MASK);

   // Transmission is allowed only on a framed, in-service, transmit-capable port.
   assign qual = ctrl_reg[`DFLC_CTRL_IN_SERVICE] &
                 ctrl_reg[`DFLC_CTRL_CBIT] & (RX_ONLY == 0);
   assign req  = {ds1_send_reg, ctrl_reg[`DFLC_CTRL_DS3_SEND]};
   // An entity needs a message when its wish differs from what was last sent.
   assign mism = (req ^ sent_reg) & {NENT{qual}};

   // Lowest pending entity wins; the DS-3 port is index zero.
   always @* begin
      pick = 5'd0;
      pick_ok = 1'b0;
      for (i = NENT - 1; i >= 0; i = i - 1) begin
         if (mism[i]) begin
            pick = i[4:0];
            pick_ok = 1'b1;
         end
      end
   end

   // Message code for an entity and a requested state.
   function [5:0] code_of;
      input [4:0] ent;
      input       act;
      begin
         if (ent == 5'd0)
            code_of = act ? `DFLC_CODE_DS3_ACT : `DFLC_CODE_DS3_DEACT;
         else if (act)
            code_of = `DFLC_CODE_DS1_ACT + {1'b0, ent - 5'd1};
         else
            code_of = `DFLC_CODE_DS1_DEACT + {1'b0, ent - 5'd1};
      end
   endfunction

   // Register writes and the interrupt status with set-over-clear.
   reg [`DFLC_INT_W-1:0] ev;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg     <= `DFLC_CTRL_RESET;
         ds1_send_reg <= {NUM_DS1{1'b0}};
         int_mask_reg <= `DFLC_INT_RESET;
         int_stat_reg <= `DFLC_INT_RESET;
      end else begin
         if (wr_en && paddr == `DFLC_OFF_CTRL)
            ctrl_reg <= pwdata[`DFLC_CTRL_W-1:0];
         if (wr_en && paddr == `DFLC_OFF_DS1_SEND)
            ds1_send_reg <= pwdata[NUM_DS1-1:0];
         if (wr_en && paddr == `DFLC_OFF_INT_MASK)
            int_mask_reg <= pwdata[`DFLC_INT_W-1:0];
         if (wr_en && paddr == `DFLC_OFF_INT_STAT)
            int_stat_reg <= (int_stat_reg & ~pwdata[`DFLC_INT_W-1:0]) | ev;
         else
            int_stat_reg <= int_stat_reg | ev;
      end
   end

   assign irq = |(int_stat_reg & int_mask_reg);

   // Read data is captured in the setup cycle so it is stable in access.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_set) begin
         case (paddr)
            `DFLC_OFF_CTRL:     prdata <= {27'h0, ctrl_reg};
            `DFLC_OFF_DS1_SEND: prdata <= {{(32-NUM_DS1){1'b0}}, ds1_send_reg};
            `DFLC_OFF_STATUS:   prdata <= {28'h0, qual,
                                           tx_state_reg[1], ds3_remote_reg,
                                           ds3_line_loop};
            `DFLC_OFF_DS1_LOOP: prdata <= {{(32-NUM_DS1){1'b0}},
                                           ds1_remote_reg};
            `DFLC_OFF_INT_STAT: prdata <= {28'h0, int_stat_reg};
            `DFLC_OFF_INT_MASK: prdata <= {28'h0, int_mask_reg};
            default:            prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Transmit sequencer: one message is a burst of identical codewords.
   wire tx_last = (tx_bit_reg == 4'd15) &&
                  (tx_rep_reg == TX_REPEAT[7:0] - 8'd1);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_state_reg <= ST_IDLE;
         sent_reg     <= {NENT{1'b0}};
         tx_sel_reg   <= 5'd0;
         tx_val_reg   <= 1'b0;
         tx_word_reg  <= 16'hFFFF;
         tx_bit_reg   <= 4'd0;
         tx_rep_reg   <= 8'd0;
         feac_tx_bit  <= 1'b1;
      end else begin
         case (tx_state_reg)
            ST_IDLE: begin
               if (feac_tx_slot)
                  feac_tx_bit <= 1'b1; // Idle channel carries ones.
               if (pick_ok) begin
                  tx_state_reg <= ST_SEND;
                  tx_sel_reg   <= pick;
                  tx_val_reg   <= req[pick];
                  tx_word_reg  <= {1'b0, code_of(pick, req[pick]), 1'b0,
                                   `DFLC_FLAG_BYTE};
                  tx_bit_reg   <= 4'd0;
                  tx_rep_reg   <= 8'd0;
               end
            end
            ST_SEND: begin
               if (!qual) begin
                  // Leaving service stops the burst at once; it restarts later.
                  tx_state_reg <= ST_IDLE;
                  feac_tx_bit  <= 1'b1;
               end else if (feac_tx_slot) begin
                  feac_tx_bit <= tx_word_reg[15];
                  tx_word_reg <= {tx_word_reg[14:0], tx_word_reg[15]};
                  tx_bit_reg  <= tx_bit_reg + 4'd1;
                  if (tx_bit_reg == 4'd15)
                     tx_rep_reg <= tx_rep_reg + 8'd1;
                  if (tx_last) begin
                     sent_reg[tx_sel_reg] <= tx_val_reg;
                     tx_state_reg <= ST_IDLE;
                  end
               end
            end
            default: tx_state_reg <= ST_IDLE;
         endcase
      end
   end

   // Receive framing: a codeword is 0 dddddd 0 then eight ones.
   wire [15:0] rx_sr_n = {rx_sr_reg[14:0], feac_rx_bit};
   wire        rx_match = feac_rx_slot && !rx_sr_n[15] && !rx_sr_n[8] &&
                          (rx_sr_n[7:0] == `DFLC_FLAG_BYTE);
   wire        rx_same = (rx_sr_n[14:9] == rx_code_reg) &&
                         (rx_gap_reg == 5'd15);
   wire [7:0]  rx_hits_n = rx_same ?
                           ((rx_hits_reg == 8'hFF) ? rx_hits_reg
                                                   : rx_hits_reg + 8'd1)
                           : 8'd1;
   // Acts once, on the codeword that completes the run.
   wire        rx_accept = rx_match && (rx_hits_n == RX_ACCEPT[7:0]) &&
                           (rx_hits_reg != RX_ACCEPT[7:0]);
   wire [5:0]  rx_code = rx_sr_n[14:9];
   wire [5:0]  ds1_act_idx = rx_code - `DFLC_CODE_DS1_ACT;
   wire [5:0]  ds1_dea_idx = rx_code - `DFLC_CODE_DS1_DEACT;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_sr_reg   <= 16'hFFFF;
         rx_gap_reg  <= 5'd16;
         rx_code_reg <= 6'h00;
         rx_hits_reg <= 8'd0;
      end else if (feac_rx_slot) begin
         rx_sr_reg <= rx_sr_n;
         if (rx_match) begin
            rx_code_reg <= rx_code;
            rx_hits_reg <= rx_hits_n;
            rx_gap_reg  <= 5'd0;
         end else if (rx_gap_reg == 5'd15) begin
            // A missing codeword breaks the consecutive run.
            rx_hits_reg <= 8'd0;
            rx_gap_reg  <= 5'd16;
         end else if (rx_gap_reg != 5'd16) begin
            rx_gap_reg <= rx_gap_reg + 5'd1;
         end
      end
   end

   // Loopback state driven by accepted codes.
   reg             ds3_remote_n;
   reg [NUM_DS1-1:0] ds1_remote_n;
   always @* begin
      ds3_remote_n = ds3_remote_reg;
      ds1_remote_n = ds1_remote_reg;
      if (rx_accept) begin
         if (!ctrl_reg[`DFLC_CTRL_IGNORE]) begin
            if (rx_code == `DFLC_CODE_DS3_ACT)
               ds3_remote_n = 1'b1;
            if (rx_code == `DFLC_CODE_DS3_DEACT)
               ds3_remote_n = 1'b0;
         end
         // Tributaries take no notice of the ignore bit.
         if (RX_ONLY == 0 && rx_code >= `DFLC_CODE_DS1_ACT &&
             ds1_act_idx < NUM_DS1)
            ds1_remote_n[ds1_act_idx[4:0]] = 1'b1;
         if (RX_ONLY == 0 && ds1_dea_idx < NUM_DS1)
            ds1_remote_n[ds1_dea_idx[4:0]] = 1'b0;
      end
   end

   always @* begin
      ev = `DFLC_INT_RESET;
      ev[`DFLC_INT_DS3_ENTER]  = ds3_remote_n & ~ds3_remote_reg;
      ev[`DFLC_INT_DS3_LEAVE]  = ~ds3_remote_n & ds3_remote_reg;
      ev[`DFLC_INT_DS1_CHANGE] = |(ds1_remote_n ^ ds1_remote_reg);
      ev[`DFLC_INT_TX_DONE]    = tx_state_reg[1] & qual & feac_tx_slot &
                                 tx_last;
   end

   // Loop state and alarms are registered so outputs never glitch.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ds3_remote_reg          <= 1'b0;
         ds1_remote_reg          <= {NUM_DS1{1'b0}};
         ds3_loop_cmd_sent_alarm <= 1'b0;
         ds1_loop_cmd_sent_alarm <= {NUM_DS1{1'b0}};
         ds3_remote_loop_alarm   <= 1'b0;
         ds1_remote_loop_alarm   <= {NUM_DS1{1'b0}};
      end else begin
         ds3_remote_reg          <= ds3_remote_n;
         ds1_remote_reg          <= ds1_remote_n;
         ds3_loop_cmd_sent_alarm <= qual & req[0];
         ds1_loop_cmd_sent_alarm <= {NUM_DS1{qual}} & ds1_send_reg;
         ds3_remote_loop_alarm   <= ds3_remote_n;
         ds1_remote_loop_alarm   <= ds1_remote_n;
      end
   end

   // Manual loopback bypasses the ignore bit entirely.
   assign ds3_line_loop = ds3_remote_reg |
                          ctrl_reg[`DFLC_CTRL_MANUAL];
   assign ds1_line_loop = ds1_remote_reg;

endmodule // dflc_ds3_far_end_loop
`default_nettype wire

// ===== common/dflc_consts.vh
// Register map, field positions, reset values and code points of the loop controller.
`ifndef DFLC_CONSTS_VH
`define DFLC_CONSTS_VH

// Register byte offsets on the APB bus.
`define DFLC_OFF_CTRL        8'h00
`define DFLC_OFF_DS1_SEND    8'h04
`define DFLC_OFF_STATUS      8'h08
`define DFLC_OFF_DS1_LOOP    8'h0C
`define DFLC_OFF_INT_STAT    8'h10
`define DFLC_OFF_INT_MASK    8'h14

// Control register fields.
`define DFLC_CTRL_IN_SERVICE 0
`define DFLC_CTRL_CBIT       1
`define DFLC_CTRL_DS3_SEND   2
`define DFLC_CTRL_IGNORE     3
`define DFLC_CTRL_MANUAL     4
`define DFLC_CTRL_W          5
`define DFLC_CTRL_RESET      5'h00

// Status register fields.
`define DFLC_ST_DS3_LOOP     0
`define DFLC_ST_DS3_REMOTE   1
`define DFLC_ST_TX_BUSY      2
`define DFLC_ST_QUALIFIED    3

// Interrupt status and mask fields.
`define DFLC_INT_DS3_ENTER   0
`define DFLC_INT_DS3_LEAVE   1
`define DFLC_INT_DS1_CHANGE  2
`define DFLC_INT_TX_DONE     3
`define DFLC_INT_W           4
`define DFLC_INT_RESET       4'h0

// Six-bit message codes carried in the codeword.
`define DFLC_CODE_DS3_ACT    6'h1E
`define DFLC_CODE_DS3_DEACT  6'h1F
`define DFLC_CODE_DS1_ACT    6'h20
`define DFLC_CODE_DS1_DEACT  6'h00

// Codeword framing: 0 dddddd 0 followed by eight ones.
`define DFLC_FLAG_BYTE       8'hFF
`define DFLC_WORD_BITS       16

// Default counts of the codeword exchange.
`define DFLC_TX_REPEAT       10
`define DFLC_RX_ACCEPT       5

`endif

// ===== tb/dflc_loop_assertions.sv
// Port checker of the far-end loop controller.
`timescale 1ns/1ns
`default_nettype none
module dflc_loop_assertions #(
   parameter NUM_DS1 = 28
) (
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic [7:0]         paddr,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [31:0]        pwdata,
   input wire logic [31:0]        prdata,
   input wire logic               pready,
   input wire logic               pslverr,
   input wire logic               feac_tx_slot,
   input wire logic               feac_tx_bit,
   input wire logic               feac_rx_slot,
   input wire logic               feac_rx_bit,
   input wire logic               ds3_line_loop,
   input wire logic [NUM_DS1-1:0] ds1_line_loop,
   input wire logic               ds3_loop_cmd_sent_alarm,
   input wire logic [NUM_DS1-1:0] ds1_loop_cmd_sent_alarm,
   input wire logic               ds3_remote_loop_alarm,
   input wire logic [NUM_DS1-1:0] ds1_remote_loop_alarm,
   input wire logic               irq
);
   logic [4:0]         ctrl_reg;
   logic [NUM_DS1-1:0] ds1_reg;
   logic [1:0]         idle_reg;
   wire                wr = psel & penable & pwrite & pready;
   wire                qual = ctrl_reg[0] & ctrl_reg[1];
   // Shadow settings; the slot count lets an aborted burst finish its bit.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= 5'h00;
         ds1_reg <= '0;
         idle_reg <= 2'h0;
      end else begin
         if (wr && paddr == 8'h00) ctrl_reg <= pwdata[4:0];
         if (wr && paddr == 8'h04) ds1_reg <= pwdata[NUM_DS1-1:0];
         if (qual) idle_reg <= 2'h0;
         else if (feac_tx_slot && idle_reg != 2'h3) idle_reg <= idle_reg + 2'h1;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_zero_wait: assert property (psel |-> pready)
      else $error("pready low");
   a_unmapped_err: assert property (psel && penable |->
      pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14}))
      else $error("pslverr wrong");
   a_manual_loop: assert property (ctrl_reg[4] |-> ds3_line_loop)
      else $error("manual loop lost");
   a_remote_alarm: assert property (ds3_remote_loop_alarm |->
      ds3_line_loop) else $error("remote alarm without loop");
   a_ds1_alarm_eq: assert property (ds1_remote_loop_alarm ==
      ds1_line_loop) else $error("ds1 alarm differs from loop");
   a_ds3_cmd_alarm: assert property (ds3_loop_cmd_sent_alarm ==
      $past(qual & ctrl_reg[2])) else $error("ds3 command alarm wrong");
   a_ds1_cmd_alarm: assert property (ds1_loop_cmd_sent_alarm ==
      $past({NUM_DS1{qual}} & ds1_reg)) else $error("ds1 alarm wrong");
   a_tx_idle_unqual: assert property (idle_reg == 2'h3 |->
      feac_tx_bit) else $error("code sent while unqualified");
   a_tx_bit_stable: assert property ($past(qual) && qual &&
      !$past(feac_tx_slot) |-> $stable(feac_tx_bit))
      else $error("tx bit moved off slot");
endmodule // dflc_loop_assertions
bind dflc_ds3_far_end_loop dflc_loop_assertions #(.NUM_DS1(NUM_DS1)) u_chk (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .feac_tx_slot(feac_tx_slot),
   .feac_tx_bit(feac_tx_bit), .feac_rx_slot(feac_rx_slot),
   .feac_rx_bit(feac_rx_bit), .ds3_line_loop(ds3_line_loop),
   .ds1_line_loop(ds1_line_loop),
   .ds3_loop_cmd_sent_alarm(ds3_loop_cmd_sent_alarm),
   .ds1_loop_cmd_sent_alarm(ds1_loop_cmd_sent_alarm),
   .ds3_remote_loop_alarm(ds3_remote_loop_alarm),
   .ds1_remote_loop_alarm(ds1_remote_loop_alarm), .irq(irq));
`default_nettype wire

// ===== tb/dflc_far_end_model.sv
// Attached line equipment: decodes codes, loops, sends codes on demand.
`timescale 1ns/1ns
`default_nettype none
`include "dflc_consts.vh"
module dflc_far_end_model (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       dut_tx_bit,
   input  wire logic       go,
   input  wire logic [5:0] code,
   input  wire logic [3:0] words,
   output logic            tx_slot,
   output logic            rx_slot,
   output logic            rx_bit,
   output logic            busy,
   output logic [5:0]      last_code,
   output logic            loop_on
);
   logic [1:0]  ph_reg;
   logic [7:0]  left_reg;
   logic [15:0] out_reg;
   logic [15:0] in_reg;
   wire  [15:0] in_next = {in_reg[14:0], dut_tx_bit};
   wire         hit = !in_next[15] && !in_next[8] && &in_next[7:0];
   assign busy = left_reg != 8'h00;
   // Slots run free; off its slot the data line toggles so no stale bit helps.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ph_reg <= 2'h0;
         left_reg <= 8'h00;
         {tx_slot, rx_slot, rx_bit, loop_on} <= 4'h2;
         in_reg <= 16'hFFFF;
         last_code <= 6'h3F;
      end else begin
         ph_reg <= ph_reg + 2'h1;
         tx_slot <= ph_reg == 2'h0;
         rx_slot <= ph_reg == 2'h2;
         rx_bit <= ph_reg != 2'h2 ? ~rx_bit : (busy ? out_reg[15] : 1'b1);
         if (go) begin
            left_reg <= {words, 4'h0};
            out_reg <= {1'b0, code, 1'b0, `DFLC_FLAG_BYTE};
         end else if (ph_reg == 2'h2 && busy) begin
            left_reg <= left_reg - 8'h01;
            out_reg <= {out_reg[14:0], out_reg[15]};
         end
         if (tx_slot) in_reg <= in_next;
         if (tx_slot && hit) begin
            last_code <= in_next[14:9];
            if (in_next[14:9] == `DFLC_CODE_DS3_ACT) loop_on <= 1'b1;
            if (in_next[14:9] == `DFLC_CODE_DS3_DEACT) loop_on <= 1'b0;
         end
      end
   end
endmodule // dflc_far_end_model
`default_nettype wire

// ===== tb/dflc_ds3_far_end_loop_bench.sv
// Self-checking bench of the DS-3 far-end loop controller.
`timescale 1ns/1ns
`default_nettype none
`include "dflc_consts.vh"
module dflc_ds3_far_end_loop_bench;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
   logic [31:0] pwdata = 32'h0, rd;
   logic [5:0]  code = 6'h00;
   logic [3:0]  words = 4'h0;
   logic        er;
   wire  [31:0] prdata;
   wire         pready, pslverr, tx_slot, tx_bit, rx_slot, rx_bit, irq;
   wire         ds3_loop, ds3_cmd, ds3_rem, busy, loop_on;
   wire  [27:0] ds1_loop, ds1_cmd, ds1_rem;
   wire  [5:0]  last_code;
   int          errors = 0, num_checks = 0, cyc = 0, n, k;
   dflc_ds3_far_end_loop #(.TX_REPEAT(2), .RX_ACCEPT(2)) dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .feac_tx_slot(tx_slot),
      .feac_tx_bit(tx_bit), .feac_rx_slot(rx_slot), .feac_rx_bit(rx_bit),
      .ds3_line_loop(ds3_loop), .ds1_line_loop(ds1_loop),
      .ds3_loop_cmd_sent_alarm(ds3_cmd), .ds1_loop_cmd_sent_alarm(ds1_cmd),
      .ds3_remote_loop_alarm(ds3_rem), .ds1_remote_loop_alarm(ds1_rem),
      .irq(irq));
   dflc_far_end_model far (.clk(pclk), .rst_n(presetn), .dut_tx_bit(tx_bit),
      .go(go), .code(code), .words(words), .tx_slot(tx_slot),
      .rx_slot(rx_slot), .rx_bit(rx_bit), .busy(busy),
      .last_code(last_code), .loop_on(loop_on));
   // Clock and a hang limit well above the few thousand cycles needed.
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         errors++;
         print_verdict;
      end
   end
   task print_verdict;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One APB transfer; a spare edge keeps back-to-back calls apart.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task feac_send(input logic [5:0] c, input logic [3:0] w);
      int j;
      code <= c;
      words <= w;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      @(posedge pclk);
      for (j = 0; busy === 1'b1 && j < 2000; j++) @(posedge pclk);
      repeat (8) @(posedge pclk);
   endtask
   task wait_code(input logic [5:0] c);
      int j;
      for (j = 0; last_code !== c && j < 600; j++) @(posedge pclk);
      chk({26'h0, last_code}, {26'h0, c});
   endtask
   function logic [5:0] ds1_code(input logic act, input int ch);
      ds1_code = (act ? `DFLC_CODE_DS1_ACT : `DFLC_CODE_DS1_DEACT) + ch[5:0];
   endfunction
   // Main sequence; one random tributary and one random run length.
   initial begin
      void'($urandom(17));
      n = $urandom % 28;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, `DFLC_OFF_CTRL, 0);
      chk(rd, 0);
      apb(0, 8'h40, 0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 0);
      apb(1, `DFLC_OFF_CTRL, 32'h6);
      repeat (300) @(posedge pclk);
      chk({26'h0, last_code}, 32'h3F);
      chk(ds3_cmd, 0);
      $display("reset, map and qualification done");
      apb(1, `DFLC_OFF_CTRL, 32'h7);
      wait_code(`DFLC_CODE_DS3_ACT);
      chk(loop_on, 1);
      chk(ds3_cmd, 1);
      rd = 0;
      for (k = 0; k < 30 && rd[3] !== 1'b1; k++) apb(0, `DFLC_OFF_INT_STAT, 0);
      apb(1, `DFLC_OFF_INT_MASK, 32'h8);
      chk(irq, 1);
      apb(1, `DFLC_OFF_INT_STAT, 32'h8);
      chk(irq, 0);
      apb(1, `DFLC_OFF_CTRL, 32'h3);
      wait_code(`DFLC_CODE_DS3_DEACT);
      chk(loop_on, 0);
      chk(ds3_cmd, 0);
      apb(1, `DFLC_OFF_DS1_SEND, 32'h1 << n);
      wait_code(ds1_code(1, n));
      chk({4'h0, ds1_cmd}, 32'h1 << n);
      apb(1, `DFLC_OFF_DS1_SEND, 0);
      wait_code(ds1_code(0, n));
      $display("transmit tests done");
      feac_send(`DFLC_CODE_DS3_ACT, 1);
      chk(ds3_loop, 0);
      feac_send(`DFLC_CODE_DS3_ACT, 4'h2 + 4'($urandom % 2));
      chk(ds3_loop, 1);
      chk(ds3_rem, 1);
      apb(0, `DFLC_OFF_STATUS, 0);
      chk(rd[1:0], 3);
      feac_send(`DFLC_CODE_DS3_DEACT, 2);
      chk({ds3_loop, ds3_rem}, 0);
      apb(1, `DFLC_OFF_CTRL, 32'hB);
      feac_send(`DFLC_CODE_DS3_ACT, 2);
      chk(ds3_loop, 0);
      feac_send(ds1_code(1, n), 2);
      chk({4'h0, ds1_loop}, 32'h1 << n);
      chk({4'h0, ds1_rem}, 32'h1 << n);
      feac_send(ds1_code(0, n), 2);
      chk({4'h0, ds1_loop}, 0);
      apb(1, `DFLC_OFF_CTRL, 32'h1B);
      chk({ds3_loop, ds3_rem}, 2);
      $display("receive tests done");
      print_verdict;
   end
endmodule // dflc_ds3_far_end_loop_bench
`default_nettype wire
